// file: rtl/ccpc_pkg.sv
// ccpc_pkg: offsets, field positions, reset words and codes for the
// clock source and pll translation block.
// assumes a 12-bit byte address space and 32-bit register words.
package ccpc_pkg;
   localparam int ADDR_W = 12;
   localparam int XLAT_W = 14;
   localparam int CRYSTAL_FREQ_CODE_W = 4;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_RUN_CFG = 12'h060;
   localparam logic [ADDR_W-1:0] OFS_XLAT = 12'h064;
   localparam logic [ADDR_W-1:0] OFS_RUN_EXT = 12'h070;
   // field positions of the configuration, extended and translation words
   localparam int MAIN_OFF_BIT = 0;
   localparam int INT_OFF_BIT = 1;
   localparam int OSC_LSB = 4;
   localparam int OSC_MSB = 5;
   localparam int EXT_OSC_MSB = 6;
   localparam int CRYSTAL_FREQ_CODE_LSB = 6;
   localparam int CRYSTAL_FREQ_CODE_MSB = 9;
   localparam int BYPASS_BIT = 11;
   localparam int POWERDOWN_BIT = 13;
   localparam int DIVISOR_LSB = 23;
   localparam int DIVISOR_MSB = 26;
   localparam int EXT_USE_BIT = 31;
   localparam int FB_LSB = 5;
   localparam int FB_MSB = 13;
   localparam int REF_MSB = 4;
   // reset words and masks of implemented bits
   localparam logic [31:0] RST_RUN_CFG = 32'h0780_3ad1;
   localparam logic [31:0] CFG_RW_MASK = 32'h0fc0_2bf3;
   localparam logic [31:0] CFG_RO1_MASK = 32'h0000_1000;
   localparam logic [31:0] RST_RUN_EXT = 32'h0000_2810;
   localparam logic [31:0] EXT_RW_MASK = 32'h8000_2870;
   localparam logic [CRYSTAL_FREQ_CODE_W-1:0] CRYSTAL_FREQ_CODE_RSV_MAX = 4'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      OSC_MAIN = 3'h0,
      OSC_INT = 3'h1,
      OSC_INT_DIV4 = 3'h2,
      OSC_30K = 3'h3
   } ccpc_osc_t;

   localparam logic [2:0] RST_PLL_REF = OSC_INT_DIV4;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] ccpc_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic ccpc_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_RUN_CFG) || (a == OFS_XLAT) || (a == OFS_RUN_EXT);
   endfunction
endpackage

// file: rtl/ccpc_regbus_if.sv
// ccpc_regbus_if: register access strobes between bus slave and regs.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ccpc_regbus_if;
   import ccpc_pkg::*;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rdata;
   logic wr_hit;
   logic rd_hit;
   modport master (output wr_en, wr_addr, wdata, wstrb, rd_addr,
                   input rdata, wr_hit, rd_hit);
   modport regs (input wr_en, wr_addr, wdata, wstrb, rd_addr,
                 output rdata, wr_hit, rd_hit);
endinterface

// file: rtl/ccpc_xlat_rom.sv
// ccpc_xlat_rom: crystal code to {feedback, reference} lookup.
// assumes the caller tolerates one cycle of read latency.
`timescale 1ns/1ps
module ccpc_xlat_rom
   import ccpc_pkg::*;
(
   input wire logic clk,
   input wire logic [CRYSTAL_FREQ_CODE_W-1:0] addr,
   output logic [XLAT_W-1:0] data_q
);
   // table for a 400 mhz vco; reserved codes read zero
   function automatic logic [XLAT_W-1:0] lut(input logic [CRYSTAL_FREQ_CODE_W-1:0] c);
      unique case (c)
         4'h4: lut = 14'h37a2;
         4'h5: lut = 14'h3602;
         4'h6: lut = 14'h31c2;
         4'h7: lut = 14'h30a2;
         4'h8: lut = 14'h32a3;
         4'h9: lut = 14'h31c3;
         4'ha: lut = 14'h30a3;
         4'hb: lut = 14'h31c4;
         4'hc: lut = 14'h30a4;
         4'hd: lut = 14'h2f45;
         4'he: lut = 14'h31c6;
         4'hf: lut = 14'h30a6;
         default: lut = 14'h0000;
      endcase
   endfunction

   // registered read port
   always_ff @(posedge clk) begin
      data_q <= lut(addr);
   end
endmodule

// file: rtl/ccpc_axil_slave.sv
// ccpc_axil_slave: axi4-lite slave front end onto ccpc_regbus_if.
// assumes one write and one read outstanding at most.
`timescale 1ns/1ps
module ccpc_axil_slave
   import ccpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   ccpc_regbus_if.master rb
);
   logic aw_q, w_q, ar_q;
   logic [ADDR_W-1:0] awa_q, ara_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   // handshakes and hold state; holds clear only when the answer is taken
   wire aw_take = awvalid & awready;
   wire w_take = wvalid & wready;
   wire ar_take = arvalid & arready;
   wire do_wr = aw_q & w_q & ~bvalid;
   wire do_rd = ar_q & ~rvalid;
   wire aw_d = (aw_q | aw_take) & ~(bvalid & bready);
   wire w_d = (w_q | w_take) & ~(bvalid & bready);
   wire ar_d = (ar_q | ar_take) & ~(rvalid & rready);
   assign rb.wr_en = do_wr;
   assign rb.wr_addr = awa_q;
   assign rb.wdata = wd_q;
   assign rb.wstrb = ws_q;
   assign rb.rd_addr = ara_q;

   // channel state; readies are registered so they come from flops
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         ar_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
         bvalid <= 1'b0;
         rvalid <= 1'b0;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         ar_q <= ar_d;
         awready <= ~aw_d;
         wready <= ~w_d;
         arready <= ~ar_d;
         bvalid <= do_wr | (bvalid & ~bready);
         rvalid <= do_rd | (rvalid & ~rready);
      end
   end

   // payload capture; unmapped addresses answer slverr
   always_ff @(posedge clk) begin
      if (rst) begin
         awa_q <= '0;
         ara_q <= '0;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         bresp <= RESP_OKAY;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
      end else begin
         if (aw_take) awa_q <= awaddr;
         if (ar_take) ara_q <= araddr;
         if (w_take) wd_q <= wdata;
         if (w_take) ws_q <= wstrb;
         if (do_wr) bresp <= rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
         if (do_rd) rresp <= rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
         if (do_rd) rdata <= rb.rdata;
      end
   end
endmodule

// file: rtl/ccpc_clock_ctrl.sv
// ccpc_clock_ctrl: system clock source selection, oscillator enables
// and read-only crystal to pll translation, behind axi4-lite.
// assumes the analogue pll and oscillators sit outside and take these
// levels as static controls; one clock, synchronous reset.
//
// Notes on behaviour
// - bypass set selects oscillator, else divided pll
// - four-bit crystal code, resets to 6 mhz
// - crystal codes 0-3 invalid while pll used
// - two-bit oscillator select, resets to internal
// - internal oscillator reaches pll only divided
// - internal oscillator off bit, resets running
// - main oscillator off bit, resets stopped
// - translation cleared in reset, loaded after release, reloaded on change
// - feedback value read-only in bits 13-5
// - reference value read-only in bits 4-0
// - translation bits 31-14 read zero
// - config word at 0x060, resets 0x07803ad1
// - powerdown bit drives pll, resets powered down
// - extended word overrides fields when selected
`timescale 1ns/1ps
module ccpc_clock_ctrl
   import ccpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic sys_from_osc_q,
   output logic [3:0] sys_divisor_q,
   output logic [2:0] osc_sel_q,
   output logic [2:0] pll_ref_sel_q,
   output logic internal_osc_off_q,
   output logic main_osc_off_q,
   output logic pll_powerdown_q,
   output logic pll_crystal_freq_code_invalid_q,
   output logic [FB_MSB-FB_LSB:0] pll_feedback_q,
   output logic [REF_MSB:0] pll_reference_q
);
   ccpc_regbus_if rb();

   logic [31:0] cfg_q;
   logic [31:0] cfg_d;
   logic [31:0] ext_q;
   logic [31:0] ext_d;
   logic [XLAT_W-1:0] xlat_q;
   logic [XLAT_W-1:0] xlat_d;
   logic [1:0] reload_q;
   logic [1:0] reload_d;
   logic [XLAT_W-1:0] rom_q;

   ccpc_axil_slave u_bus (
      .clk(clk),
      .rst(rst),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .awaddr(s_axi_awaddr),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .bresp(s_axi_bresp),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .araddr(s_axi_araddr),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rb(rb)
   );

   // write decode
   wire wr_cfg = rb.wr_en & (rb.wr_addr == OFS_RUN_CFG);
   wire wr_ext = rb.wr_en & (rb.wr_addr == OFS_RUN_EXT);
   wire wr_xlat = rb.wr_en & (rb.wr_addr == OFS_XLAT);
   assign rb.wr_hit = ccpc_mapped(rb.wr_addr);
   assign rb.rd_hit = ccpc_mapped(rb.rd_addr);

   // masks pin reserved bits, so software cannot disturb them
   wire [31:0] cfg_wr = ccpc_merge(cfg_q, rb.wdata, rb.wstrb);
   wire [31:0] ext_wr = ccpc_merge(ext_q, rb.wdata, rb.wstrb);
   assign cfg_d = wr_cfg ? ((cfg_wr & CFG_RW_MASK) | CFG_RO1_MASK) : cfg_q;
   assign ext_d = wr_ext ? (ext_wr & EXT_RW_MASK) : ext_q;

   // crystal code and change detect; a rewrite of the same code is no reload
   wire [CRYSTAL_FREQ_CODE_W-1:0] crystal_freq_code_now = cfg_q[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB];
   wire [CRYSTAL_FREQ_CODE_W-1:0] crystal_freq_code_next = cfg_d[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB];
   wire crystal_freq_code_change = wr_cfg & (crystal_freq_code_next != crystal_freq_code_now);

   // two stages: one for the code to land, one for the rom read
   assign reload_d = {reload_q[0], crystal_freq_code_change};
   assign xlat_d = reload_q[1] ? rom_q : xlat_q;

   ccpc_xlat_rom u_rom (
      .clk(clk),
      .addr(crystal_freq_code_now),
      .data_q(rom_q)
   );

   // extended word takes over bypass, powerdown and source
   wire use_ext = ext_q[EXT_USE_BIT];
   wire eff_bypass = use_ext ? ext_q[BYPASS_BIT] : cfg_q[BYPASS_BIT];
   wire eff_powerdown = use_ext ? ext_q[POWERDOWN_BIT] : cfg_q[POWERDOWN_BIT];
   wire [2:0] eff_osc = use_ext ? ext_q[EXT_OSC_MSB:OSC_LSB]
                                : {1'b0, cfg_q[OSC_MSB:OSC_LSB]};

   // pll use checks; the undivided internal source is never the reference
   wire pll_used = ~eff_bypass;
   wire crystal_freq_code_bad = pll_used & (crystal_freq_code_now <= CRYSTAL_FREQ_CODE_RSV_MAX);
   wire [2:0] ref_sel = (eff_osc == OSC_INT) ? OSC_INT_DIV4 : eff_osc;

   // read mux; translation zero-extends so upper bits read zero
   assign rb.rdata = (rb.rd_addr == OFS_RUN_CFG) ? cfg_q :
                     (rb.rd_addr == OFS_XLAT) ? 32'(xlat_q) :
                     (rb.rd_addr == OFS_RUN_EXT) ? ext_q :
                     32'h0000_0000;

   // register file; translation clears in reset and loads after release
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_q <= RST_RUN_CFG;
         ext_q <= RST_RUN_EXT;
         xlat_q <= '0;
         reload_q <= 2'h3;
      end else begin
         cfg_q <= cfg_d;
         ext_q <= ext_d;
         xlat_q <= xlat_d;
         reload_q <= reload_d;
      end
   end

   // source and divider controls, registered toward the clock tree
   always_ff @(posedge clk) begin
      if (rst) begin
         sys_from_osc_q <= RST_RUN_CFG[BYPASS_BIT];
         sys_divisor_q <= RST_RUN_CFG[DIVISOR_MSB:DIVISOR_LSB];
         osc_sel_q <= {1'b0, RST_RUN_CFG[OSC_MSB:OSC_LSB]};
         pll_ref_sel_q <= RST_PLL_REF;
         pll_crystal_freq_code_invalid_q <= 1'b0;
      end else begin
         sys_from_osc_q <= eff_bypass;
         sys_divisor_q <= cfg_q[DIVISOR_MSB:DIVISOR_LSB];
         osc_sel_q <= eff_osc;
         pll_ref_sel_q <= ref_sel;
         pll_crystal_freq_code_invalid_q <= crystal_freq_code_bad;
      end
   end

   // analogue enables; powerdown follows the field the extended word selects
   always_ff @(posedge clk) begin
      if (rst) begin
         internal_osc_off_q <= RST_RUN_CFG[INT_OFF_BIT];
         main_osc_off_q <= RST_RUN_CFG[MAIN_OFF_BIT];
         pll_powerdown_q <= RST_RUN_CFG[POWERDOWN_BIT];
      end else begin
         internal_osc_off_q <= cfg_q[INT_OFF_BIT];
         main_osc_off_q <= cfg_q[MAIN_OFF_BIT];
         pll_powerdown_q <= eff_powerdown;
      end
   end

   // pll inputs are the translation flop itself
   assign pll_feedback_q = xlat_q[FB_MSB:FB_LSB];
   assign pll_reference_q = xlat_q[REF_MSB:0];

   // checks next to the logic
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // a bypass write reaches the source select two edges later
   property p_bypass_src;
      (wr_cfg && !use_ext && rb.wstrb[1])
      |-> ##2 (sys_from_osc_q == $past(rb.wdata[BYPASS_BIT], 2));
   endproperty
   a_bypass_src: assert property (p_bypass_src)
      else $error("system source does not follow bypass write");

   // crystal code lands one edge after its write
   property p_crystal_freq_code_store;
      (wr_cfg && rb.wstrb[0] && rb.wstrb[1])
      |=> (crystal_freq_code_now == $past(rb.wdata[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB]));
   endproperty
   a_crystal_freq_code_store: assert property (p_crystal_freq_code_store)
      else $error("crystal code not stored");

   // invalid flag tracks reserved code while the pll is used
   property p_crystal_freq_code_invalid;
      ##1 (pll_crystal_freq_code_invalid_q ==
           ($past(!eff_bypass) && ($past(crystal_freq_code_now) <= CRYSTAL_FREQ_CODE_RSV_MAX)));
   endproperty
   a_crystal_freq_code_invalid: assert property (p_crystal_freq_code_invalid)
      else $error("reserved crystal flag wrong");

   // oscillator select comes out of reset as internal
   property p_osc_reset;
      $fell(rst) |-> (osc_sel_q == OSC_INT);
   endproperty
   a_osc_reset: assert property (p_osc_reset)
      else $error("oscillator select reset value wrong");

   // reference select never shows the undivided internal source
   property p_ref_divided;
      (pll_ref_sel_q != OSC_INT)
      and ((osc_sel_q == OSC_INT) |-> (pll_ref_sel_q == OSC_INT_DIV4));
   endproperty
   a_ref_divided: assert property (p_ref_divided)
      else $error("internal oscillator reaches pll undivided");

   // internal oscillator off follows its bit two edges after write
   property p_int_off;
      (wr_cfg && rb.wstrb[0])
      |-> ##2 (internal_osc_off_q == $past(rb.wdata[INT_OFF_BIT], 2));
   endproperty
   a_int_off: assert property (p_int_off)
      else $error("internal oscillator enable wrong");

   // main oscillator off follows its bit two edges after write
   property p_main_off;
      (wr_cfg && rb.wstrb[0])
      |-> ##2 (main_osc_off_q == $past(rb.wdata[MAIN_OFF_BIT], 2));
   endproperty
   a_main_off: assert property (p_main_off)
      else $error("main oscillator enable wrong");

   // a code change reloads the translation three edges later
   property p_reload;
      crystal_freq_code_change |-> ##3 (xlat_q == rom_q);
   endproperty
   a_reload: assert property (p_reload)
      else $error("translation not reloaded after crystal change");

   // writes to the translation word leave the feedback value alone
   property p_fb_ro;
      (wr_xlat && (reload_q == 2'h0))
      |=> (pll_feedback_q == $past(pll_feedback_q));
   endproperty
   a_fb_ro: assert property (p_fb_ro)
      else $error("feedback value changed by a write");

   // read data leaving the bus carries the reference field
   property p_ref_read;
      ($rose(s_axi_rvalid) && (rb.rd_addr == OFS_XLAT))
      |-> (s_axi_rdata[REF_MSB:0] == $past(pll_reference_q));
   endproperty
   a_ref_read: assert property (p_ref_read)
      else $error("reference value readback wrong");

   // upper translation bits read zero
   property p_xlat_upper;
      ($rose(s_axi_rvalid) && (rb.rd_addr == OFS_XLAT)) |-> (s_axi_rdata[31:XLAT_W] == '0);
   endproperty
   a_xlat_upper: assert property (p_xlat_upper)
      else $error("translation upper bits not zero");

   // configuration word holds its reset value after release
   property p_cfg_reset;
      $fell(rst) |-> (cfg_q == RST_RUN_CFG);
   endproperty
   a_cfg_reset: assert property (p_cfg_reset)
      else $error("configuration reset value wrong");

   // powerdown follows the selected field one edge later
   property p_powerdown;
      ##1 (pll_powerdown_q == $past(eff_powerdown));
   endproperty
   a_powerdown: assert property (p_powerdown)
      else $error("pll powerdown does not follow field");

   // with the extended word selected its source wins
   property p_ext_override;
      use_ext |=> (osc_sel_q == $past(ext_q[EXT_OSC_MSB:OSC_LSB]));
   endproperty
   a_ext_override: assert property (p_ext_override)
      else $error("extended source not applied");

   // reserved bits keep their fixed values
   property p_reserved;
      ((cfg_q & ~(CFG_RW_MASK | CFG_RO1_MASK)) == '0) && ((cfg_q & CFG_RO1_MASK) != '0);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved configuration bits disturbed");
endmodule

// file: tb/ccpc_clock_ctrl_test.sv
// ccpc_clock_ctrl_test: self-checking bench for the clock source block.
// assumes ccpc_pkg and the design files are compiled first; drives axi4-lite itself.
`timescale 1ns/1ps
module ccpc_clock_ctrl_test;
   import ccpc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awvalid = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic wvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic [ADDR_W-1:0] araddr = '0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic sys_from_osc_q, internal_osc_off_q, main_osc_off_q, pll_powerdown_q;
   logic pll_crystal_freq_code_invalid_q;
   logic [3:0] sys_divisor_q;
   logic [2:0] osc_sel_q, pll_ref_sel_q;
   logic [FB_MSB-FB_LSB:0] pll_feedback_q;
   logic [REF_MSB:0] pll_reference_q;
   // reference model state: stored words and the crystal lookup
   logic [31:0] cfg_m, ext_m;
   int fb_t[16] = '{0, 0, 0, 0, 445, 432, 398, 389, 405, 398, 389, 398, 389, 378, 398, 389};
   int rf_t[16] = '{0, 0, 0, 0, 2, 2, 2, 2, 3, 3, 3, 4, 4, 5, 6, 6};
   int fail_count = 0;
   int tests_run = 0;

   always #2.5 clk = ~clk;

   ccpc_clock_ctrl dut_u (.clk(clk), .rst(rst), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .sys_from_osc_q(sys_from_osc_q), .sys_divisor_q(sys_divisor_q),
      .osc_sel_q(osc_sel_q), .pll_ref_sel_q(pll_ref_sel_q),
      .internal_osc_off_q(internal_osc_off_q), .main_osc_off_q(main_osc_off_q),
      .pll_powerdown_q(pll_powerdown_q), .pll_crystal_freq_code_invalid_q(pll_crystal_freq_code_invalid_q),
      .pll_feedback_q(pll_feedback_q), .pll_reference_q(pll_reference_q));

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic tmo;
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      end_sim();
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // handshakes are judged at the falling edge so the next rising edge acts on settled values
   task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
      bit ta, tw, tb, done;
      int n;
      done = 0;
      n = 0;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      while (!done) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            done = 1;
         end
         n++;
         if (n > 40) tmo();
      end
   endtask

   task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ta, done;
      int n;
      done = 0;
      n = 0;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (!done) begin
         @(negedge clk);
         ta = arvalid && arready;
         done = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (done) rready <= 1'b0;
         n++;
         if (n > 40) tmo();
      end
   endtask

   function automatic logic [31:0] lane(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
      end
      return o;
   endfunction

   // write through the bus and mirror it in the model, then let outputs settle
   task automatic mw(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axw(a, d, s, r);
      if (a == OFS_RUN_CFG) cfg_m = (lane(cfg_m, d, s) & CFG_RW_MASK) | CFG_RO1_MASK;
      if (a == OFS_RUN_EXT) ext_m = lane(ext_m, d, s) & EXT_RW_MASK;
      chk(r, (a inside {OFS_RUN_CFG, OFS_XLAT, OFS_RUN_EXT}) ? RESP_OKAY : RESP_SLVERR);
      repeat (4) @(posedge clk);
   endtask

   // compare every output and all three registers with the model
   task automatic rd3;
      logic [31:0] d;
      logic [1:0] r;
      logic [2:0] o;
      logic byp, pd;
      int x;
      byp = cfg_m[BYPASS_BIT];
      pd = cfg_m[POWERDOWN_BIT];
      o = {1'b0, cfg_m[OSC_MSB:OSC_LSB]};
      if (ext_m[EXT_USE_BIT]) begin
         byp = ext_m[BYPASS_BIT];
         pd = ext_m[POWERDOWN_BIT];
         o = ext_m[EXT_OSC_MSB:OSC_LSB];
      end
      x = int'(cfg_m[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB]);
      chk(sys_from_osc_q, byp);
      chk(sys_divisor_q, cfg_m[DIVISOR_MSB:DIVISOR_LSB]);
      chk(osc_sel_q, o);
      chk(pll_ref_sel_q, (o == 3'h1) ? 3'h2 : o);
      chk(internal_osc_off_q, cfg_m[INT_OFF_BIT]);
      chk(main_osc_off_q, cfg_m[MAIN_OFF_BIT]);
      chk(pll_powerdown_q, pd);
      chk(pll_crystal_freq_code_invalid_q, !byp && x <= 3);
      chk(pll_feedback_q, 32'(fb_t[x]));
      chk(pll_reference_q, 32'(rf_t[x]));
      axr(OFS_RUN_CFG, d, r);
      chk(d, cfg_m);
      chk(r, RESP_OKAY);
      axr(OFS_XLAT, d, r);
      chk(d, 32'((fb_t[x] << 5) | rf_t[x]));
      axr(OFS_RUN_EXT, d, r);
      chk(d, ext_m);
   endtask

   task automatic do_rst;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      cfg_m = RST_RUN_CFG;
      ext_m = RST_RUN_EXT;
      repeat (2) @(posedge clk);
   endtask

   // hang guard, well beyond the full sequence
   initial begin
      repeat (100000) @(posedge clk);
      tmo();
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [ADDR_W-1:0] a;
      void'($urandom(16700));
      do_rst();
      rd3();
      // every writable and reserved bit set, then all cleared
      mw(OFS_RUN_CFG, 32'hffff_ffff, 4'hf);
      rd3();
      mw(OFS_RUN_CFG, 32'h0000_0000, 4'hf);
      rd3();
      // each crystal code with one of the four sources in turn, pll used on the lower half
      for (int i = 0; i < 16; i++) begin
         mw(OFS_RUN_CFG, 32'((i << 6) | ((i % 4) << 4) | ((i / 8) << 11) | ((i % 2) << 13)), 4'hf);
         rd3();
      end
      mw(OFS_RUN_CFG, cfg_m, 4'hf);
      rd3();
      // read-only translation and an unmapped word
      mw(OFS_XLAT, 32'hffff_ffff, 4'hf);
      rd3();
      mw(12'h068, 32'hffff_ffff, 4'hf);
      axr(12'h068, d, r);
      chk(d, 32'h0000_0000);
      chk(r, RESP_SLVERR);
      // extended word takes over source, bypass and powerdown
      mw(OFS_RUN_EXT, 32'h8000_0010, 4'hf);
      rd3();
      mw(OFS_RUN_EXT, 32'h0000_0000, 4'hf);
      rd3();
      // random contents and byte lanes on both writable words
      repeat (40) begin
         a = ($urandom_range(0, 1) == 0) ? OFS_RUN_CFG : OFS_RUN_EXT;
         mw(a, $urandom, 4'($urandom_range(0, 15)));
         rd3();
      end
      // second reset in mid-run restores everything
      do_rst();
      rd3();
      end_sim();
   end
endmodule
